// ---- src/fmt_pkg.sv ----
package fmt_pkg;

// ==========================================
// integer formats
localparam int REG_W = 64;
localparam int WORD_W = 32;
localparam int TAG_W = 2;
localparam int TAGVAL_W = 30;

typedef enum logic [1:0] {
    INT_BYTE,
    INT_HALF,
    INT_WORD,
    INT_DOUBLE
} int_size_t;

typedef enum logic [1:0] {
    FP_SINGLE,
    FP_DOUBLE,
    FP_QUAD
} fp_prec_t;

typedef enum logic [2:0] {
    CLS_ZERO,
    CLS_SUBNORMAL,
    CLS_NORMAL,
    CLS_INFINITY,
    CLS_QNAN,
    CLS_SNAN
} fp_class_t;

// ==========================================
// floating-point field layout
localparam int SP_EXP_W = 8;
localparam int SP_FRAC_W = 23;
localparam int DP_EXP_W = 11;
localparam int DP_FRAC_W = 52;
localparam int QP_EXP_W = 15;
localparam int QP_FRAC_W = 112;
localparam logic [15:0] SP_BIAS = 16'h007f;
localparam logic [15:0] DP_BIAS = 16'h03ff;
localparam logic [15:0] QP_BIAS = 16'h3fff;
localparam logic [15:0] SP_EMIN = 16'hff82;
localparam logic [15:0] DP_EMIN = 16'hfc02;
localparam logic [15:0] QP_EMIN = 16'hc002;

// ==========================================
// alignment and register numbering
localparam logic [2:0] WORD_ALIGN_MASK = 3'h3;
localparam logic [3:0] DBL_ALIGN_MASK = 4'h7;
localparam logic [3:0] QUAD_ALIGN_MASK = 4'hf;
localparam logic [5:0] ODD_REG_LIMIT = 6'h1f;

typedef struct packed {
    logic sign;
    logic [15:0] exp_unbiased;
    logic [QP_FRAC_W-1:0] frac;
    logic implicit_one;
    fp_class_t cls;
} fp_decoded_t;

typedef struct packed {
    logic [REG_W-1:0] signed_value;
    logic [REG_W-1:0] unsigned_value;
    logic [TAG_W-1:0] tag;
    logic [REG_W-1:0] tag_value;
} int_decoded_t;

endpackage

// ---- src/fp_classify.sv ----
`timescale 1ns/1ps
module fp_classify
    import fmt_pkg::*;
(
    input wire fp_prec_t prec,
    input wire logic [127:0] value,
    output fp_decoded_t dec
);
    logic [QP_EXP_W-1:0] e;
    logic [QP_EXP_W-1:0] emax;
    logic [15:0] bias;
    logic [15:0] emin;
    logic [QP_FRAC_W-1:0] f;
    logic msb;

    always_comb begin
        e = '0;
        f = '0;
        emax = '0;
        bias = SP_BIAS;
        emin = SP_EMIN;
        dec.sign = 1'b0;
        case (prec)
            FP_SINGLE: begin
                dec.sign = value[31];
                e = {7'h00, value[30:23]};
                f = {value[22:0], 89'h0};
                emax = 15'h00ff;
            end
            FP_DOUBLE: begin
                dec.sign = value[63];
                e = {4'h0, value[62:52]};
                f = {value[51:0], 60'h0};
                emax = 15'h07ff;
                bias = DP_BIAS;
                emin = DP_EMIN;
            end
            default: begin
                dec.sign = value[127];
                e = value[126:112];
                f = value[111:0];
                emax = 15'h7fff;
                bias = QP_BIAS;
                emin = QP_EMIN;
            end
        endcase
        msb = f[QP_FRAC_W-1];
        dec.frac = f;
        dec.implicit_one = 1'b0;
        dec.exp_unbiased = emin;
        if (e == emax) begin
            if (f == '0) begin
                dec.cls = CLS_INFINITY;
            end else if (msb) begin
                dec.cls = CLS_QNAN;
            end else begin
                dec.cls = CLS_SNAN;
            end
        end else if (e == '0) begin
            dec.cls = (f == '0) ? CLS_ZERO : CLS_SUBNORMAL;
        end else begin
            dec.cls = CLS_NORMAL;
            dec.implicit_one = 1'b1;
            dec.exp_unbiased = {1'b0, e} - bias;
        end
    end
endmodule

// ---- src/mem_layout.sv ----
`timescale 1ns/1ps
module mem_layout
    import fmt_pkg::*;
(
    input wire logic little_endian,
    input wire logic [127:0] value,
    output logic [127:0] mem_image
);
    logic [127:0] be_image;

    always_comb begin
        be_image = value;
        mem_image = be_image;
        if (little_endian) begin
            for (int i = 0; i < 16; i++) begin
                mem_image[i*8 +: 8] = be_image[(15-i)*8 +: 8];
            end
        end
    end
endmodule

// ---- src/data_format_unpacker.sv ----
`timescale 1ns/1ps
// What this block does
// - signed integers sign-extend as two's complement
// - unsigned data zero-extends to register width
// - tagged word: low two bits tag
// - integer results are 64 bits wide
// - doubleword and extended-word share memory layout
// - big-endian: high word at lowest address
// - little-endian reverses word and byte order
// - float encodings follow binary IEEE 754
// - single: sign, 8-bit exponent, 23-bit fraction
// - normal bias 127; exponent zero subnormal
// - zero exponent and fraction is signed zero
// - double: 11-bit exponent, bias 1023, 52 fraction
// - quad: 15-bit exponent, bias 16383, 112 fraction
// - max exponent, fraction msb set: quiet NaN
// - max exponent, msb clear, nonzero: signalling NaN
// - max exponent, zero fraction: signed infinity
// - double accepted word-aligned; 8-byte only advised
// - quad accepted word-aligned; 16-byte only advised
// - odd halves addressable only at register <=31
module data_format_unpacker
    import fmt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire int_size_t int_size,
    input wire logic [63:0] int_operand,
    input wire fp_prec_t fp_prec,
    input wire logic [127:0] fp_operand,
    input wire logic little_endian,
    input wire logic [31:0] mem_addr,
    input wire logic [5:0] fp_reg_num,
    input wire logic [4:0] pair_reg_num,
    output logic result_valid_r,
    output int_decoded_t int_result_r,
    output fp_decoded_t fp_result_r,
    output logic [127:0] mem_image_r,
    output logic [31:0] signed_double_high_word_r,
    output logic [31:0] signed_double_low_word_r,
    output logic [63:0] signed_extended_value_r,
    output logic [31:0] unsigned_double_high_word_r,
    output logic [31:0] unsigned_double_low_word_r,
    output logic [63:0] unsigned_extended_value_r,
    output logic [31:0] fp_double_upper_word_r,
    output logic [31:0] fp_double_lower_word_r,
    output logic [31:0] fp_quad_word_first_r,
    output logic [31:0] fp_quad_word_second_r,
    output logic [31:0] fp_quad_word_third_r,
    output logic [31:0] fp_quad_word_fourth_r,
    output logic [4:0] pair_high_reg_r,
    output logic [4:0] pair_low_reg_r,
    output logic align_error_r,
    output logic align_advised_r,
    output logic odd_reg_ok_r
);
    // ==========================================
    // submodules
    fp_decoded_t fp_dec;
    logic [127:0] mem_image;
    logic [127:0] layout_in;

    fp_classify u_classify (
        .prec(fp_prec),
        .value(fp_operand),
        .dec(fp_dec)
    );

    mem_layout u_layout (
        .little_endian(little_endian),
        .value(layout_in),
        .mem_image(mem_image)
    );

    // ==========================================
    // integer extension
    logic [63:0] sx;
    logic [63:0] ux;

    always_comb begin
        case (int_size)
            INT_BYTE: begin
                sx = {{56{int_operand[7]}}, int_operand[7:0]};
                ux = {56'h0, int_operand[7:0]};
            end
            INT_HALF: begin
                sx = {{48{int_operand[15]}}, int_operand[15:0]};
                ux = {48'h0, int_operand[15:0]};
            end
            INT_WORD: begin
                sx = {{32{int_operand[31]}}, int_operand[31:0]};
                ux = {32'h0, int_operand[31:0]};
            end
            default: begin
                sx = int_operand;
                ux = int_operand;
            end
        endcase
        layout_in = (fp_prec == FP_SINGLE || fp_prec == FP_QUAD) ? fp_operand
                                                                  : {64'h0, int_operand};
        if (fp_prec == FP_DOUBLE) begin
            layout_in = {64'h0, fp_operand[63:0]};
        end
    end

    // ==========================================
    // result strobe
    logic result_valid_nxt;

    always_comb begin
        result_valid_nxt = op_valid;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_valid_r <= 1'b0;
        end else begin
            result_valid_r <= result_valid_nxt;
        end
    end

    // ==========================================
    // integer results
    int_decoded_t int_nxt;
    logic [31:0] sd_hi_nxt;
    logic [31:0] sd_lo_nxt;
    logic [63:0] sx_nxt;
    logic [31:0] ud_hi_nxt;
    logic [31:0] ud_lo_nxt;
    logic [63:0] ux_nxt;

    always_comb begin
        int_nxt = int_result_r;
        sd_hi_nxt = signed_double_high_word_r;
        sd_lo_nxt = signed_double_low_word_r;
        sx_nxt = signed_extended_value_r;
        ud_hi_nxt = unsigned_double_high_word_r;
        ud_lo_nxt = unsigned_double_low_word_r;
        ux_nxt = unsigned_extended_value_r;
        if (op_valid) begin
            int_nxt.signed_value = sx;
            int_nxt.unsigned_value = ux;
            int_nxt.tag = int_operand[TAG_W-1:0];
            int_nxt.tag_value = {{34{int_operand[31]}}, int_operand[31:TAG_W]};
            sd_hi_nxt = sx[63:32];
            sd_lo_nxt = sx[31:0];
            sx_nxt = sx;
            ud_hi_nxt = ux[63:32];
            ud_lo_nxt = ux[31:0];
            ux_nxt = ux;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            int_result_r <= '0;
            signed_double_high_word_r <= '0;
            signed_double_low_word_r <= '0;
            signed_extended_value_r <= '0;
            unsigned_double_high_word_r <= '0;
            unsigned_double_low_word_r <= '0;
            unsigned_extended_value_r <= '0;
        end else begin
            int_result_r <= int_nxt;
            signed_double_high_word_r <= sd_hi_nxt;
            signed_double_low_word_r <= sd_lo_nxt;
            signed_extended_value_r <= sx_nxt;
            unsigned_double_high_word_r <= ud_hi_nxt;
            unsigned_double_low_word_r <= ud_lo_nxt;
            unsigned_extended_value_r <= ux_nxt;
        end
    end

    // ==========================================
    // register pair
    logic [4:0] pair_hi_nxt;
    logic [4:0] pair_lo_nxt;

    always_comb begin
        pair_hi_nxt = pair_high_reg_r;
        pair_lo_nxt = pair_low_reg_r;
        if (op_valid) begin
            pair_hi_nxt = {pair_reg_num[4:1], 1'b0};
            pair_lo_nxt = {pair_reg_num[4:1], 1'b1};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pair_high_reg_r <= '0;
            pair_low_reg_r <= '0;
        end else begin
            pair_high_reg_r <= pair_hi_nxt;
            pair_low_reg_r <= pair_lo_nxt;
        end
    end

    // ==========================================
    // float decode
    fp_decoded_t fp_nxt;

    always_comb begin
        fp_nxt = fp_result_r;
        if (op_valid) begin
            fp_nxt = fp_dec;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fp_result_r <= '0;
        end else begin
            fp_result_r <= fp_nxt;
        end
    end

    // ==========================================
    // float word split
    logic [31:0] fd_hi_nxt;
    logic [31:0] fd_lo_nxt;
    logic [31:0] q0_nxt;
    logic [31:0] q1_nxt;
    logic [31:0] q2_nxt;
    logic [31:0] q3_nxt;

    always_comb begin
        fd_hi_nxt = fp_double_upper_word_r;
        fd_lo_nxt = fp_double_lower_word_r;
        q0_nxt = fp_quad_word_first_r;
        q1_nxt = fp_quad_word_second_r;
        q2_nxt = fp_quad_word_third_r;
        q3_nxt = fp_quad_word_fourth_r;
        if (op_valid) begin
            fd_hi_nxt = fp_operand[63:32];
            fd_lo_nxt = fp_operand[31:0];
            q0_nxt = fp_operand[127:96];
            q1_nxt = fp_operand[95:64];
            q2_nxt = fp_operand[63:32];
            q3_nxt = fp_operand[31:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fp_double_upper_word_r <= '0;
            fp_double_lower_word_r <= '0;
            fp_quad_word_first_r <= '0;
            fp_quad_word_second_r <= '0;
            fp_quad_word_third_r <= '0;
            fp_quad_word_fourth_r <= '0;
        end else begin
            fp_double_upper_word_r <= fd_hi_nxt;
            fp_double_lower_word_r <= fd_lo_nxt;
            fp_quad_word_first_r <= q0_nxt;
            fp_quad_word_second_r <= q1_nxt;
            fp_quad_word_third_r <= q2_nxt;
            fp_quad_word_fourth_r <= q3_nxt;
        end
    end

    // ==========================================
    // memory image
    logic [127:0] mem_nxt;

    always_comb begin
        mem_nxt = mem_image_r;
        if (op_valid) begin
            mem_nxt = mem_image;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_image_r <= '0;
        end else begin
            mem_image_r <= mem_nxt;
        end
    end

    // ==========================================
    // alignment and register flags
    logic align_err_nxt;
    logic align_adv_nxt;
    logic odd_ok_nxt;

    always_comb begin
        align_err_nxt = align_error_r;
        align_adv_nxt = align_advised_r;
        odd_ok_nxt = odd_reg_ok_r;
        if (op_valid) begin
            align_err_nxt = (mem_addr[1:0] & WORD_ALIGN_MASK[1:0]) != 2'h0;
            case (fp_prec)
                FP_DOUBLE: align_adv_nxt = (mem_addr[3:0] & DBL_ALIGN_MASK) == 4'h0;
                FP_QUAD: align_adv_nxt = (mem_addr[3:0] & QUAD_ALIGN_MASK) == 4'h0;
                default: align_adv_nxt = 1'b1;
            endcase
            odd_ok_nxt = !fp_reg_num[0] || (fp_reg_num <= ODD_REG_LIMIT);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            align_error_r <= 1'b0;
            align_advised_r <= 1'b0;
            odd_reg_ok_r <= 1'b0;
        end else begin
            align_error_r <= align_err_nxt;
            align_advised_r <= align_adv_nxt;
            odd_reg_ok_r <= odd_ok_nxt;
        end
    end
endmodule

// ---- testbench/fmt_checker_sva.sv ----
`timescale 1ns/1ps
// ====
// result checks
module fmt_checker
    import fmt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire int_size_t int_size,
    input wire logic [63:0] int_operand,
    input wire fp_prec_t fp_prec,
    input wire logic [127:0] fp_operand,
    input wire logic [31:0] mem_addr,
    input wire logic [5:0] fp_reg_num,
    input wire logic [4:0] pair_reg_num,
    input wire logic result_valid_r,
    input wire int_decoded_t int_result_r,
    input wire fp_decoded_t fp_result_r,
    input wire logic [63:0] signed_extended_value_r,
    input wire logic [31:0] signed_double_high_word_r,
    input wire logic [31:0] signed_double_low_word_r,
    input wire logic [31:0] fp_quad_word_first_r,
    input wire logic [31:0] fp_quad_word_fourth_r,
    input wire logic [4:0] pair_high_reg_r,
    input wire logic [4:0] pair_low_reg_r,
    input wire logic align_error_r,
    input wire logic odd_reg_ok_r
);
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
sequence taken_s;
    op_valid;
endsequence
sequence pulse_s;
    result_valid_r ##1 !result_valid_r;
endsequence
valid_pulse_a: assert property (taken_s ##1 !op_valid |-> pulse_s)
    else $error("result strobe is not one cycle");
sign_ext_a: assert property (taken_s ##0 (int_size == INT_BYTE) |=>
    int_result_r.signed_value == 64'($signed($past(int_operand[7:0]))))
    else $error("byte not sign extended");
zero_ext_a: assert property (taken_s ##0 (int_size == INT_HALF) |=>
    int_result_r.unsigned_value == {48'h0, $past(int_operand[15:0])})
    else $error("half not zero extended");
tag_split_a: assert property (taken_s |=> int_result_r.tag == $past(int_operand[1:0]) &&
    int_result_r.tag_value == 64'($signed($past(int_operand[31:2]))))
    else $error("tagged word split wrong");
ext_words_a: assert property (result_valid_r |->
    {signed_double_high_word_r, signed_double_low_word_r} == signed_extended_value_r &&
    signed_extended_value_r == int_result_r.signed_value)
    else $error("doubleword halves disagree");
quad_words_a: assert property (taken_s |=> fp_quad_word_first_r == $past(fp_operand[127:96]) &&
    fp_quad_word_fourth_r == $past(fp_operand[31:0]))
    else $error("quad words wrong");
sgl_fields_a: assert property (taken_s ##0 (fp_prec == FP_SINGLE) |=>
    fp_result_r.sign == $past(fp_operand[31]) && fp_result_r.frac[111:89] == $past(fp_operand[22:0]))
    else $error("single fields wrong");
word_align_a: assert property (taken_s |=> align_error_r == ($past(mem_addr[1:0]) != 2'h0))
    else $error("word alignment flag wrong");
odd_reg_a: assert property (taken_s |=>
    odd_reg_ok_r == (!$past(fp_reg_num[0]) || $past(fp_reg_num) <= 6'h1f))
    else $error("odd register flag wrong");
pair_split_a: assert property (taken_s |=> pair_high_reg_r == ($past(pair_reg_num) & 5'h1e) &&
    pair_low_reg_r == ($past(pair_reg_num) | 5'h01))
    else $error("register pair wrong");
qnan_msb_a: assert property (result_valid_r && fp_result_r.cls == CLS_QNAN |-> fp_result_r.frac[111])
    else $error("quiet nan without fraction msb");
endmodule
bind data_format_unpacker fmt_checker chk_u (.*);

// ---- testbench/lsu_model.sv ----
`timescale 1ns/1ps
// ====
// load/store side: addresses and register numbers
module lsu_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire logic misalign,
    output logic [31:0] mem_addr,
    output logic [5:0] fp_reg_num,
    output logic [4:0] pair_reg_num
);
int seed = 32'h70892eac;
logic [31:0] base_r;
assign mem_addr = {base_r[31:2], misalign, 1'b0};
always @(posedge clk) begin
    if (sys_rst)
        {base_r, fp_reg_num, pair_reg_num} <= 43'h0;
    else if (op_valid)
        {base_r, fp_reg_num, pair_reg_num} <= 43'({$random(seed), $random(seed)});
end
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
// ====
// self-checking bench
module tb;
import fmt_pkg::*;
typedef struct packed {
    int_decoded_t i;
    fp_decoded_t f;
    logic [127:0] m;
    logic [12:0] g;
    logic [127:0] w;
} exp_t;
logic clk = 0, sys_rst = 1, op_valid = 0, little_endian = 0, misalign = 0;
int_size_t int_size = INT_BYTE;
fp_prec_t fp_prec = FP_SINGLE;
logic [63:0] int_operand = 64'h0;
logic [127:0] fp_operand = 128'h0, mem_image_r;
logic [31:0] mem_addr, r;
logic [5:0] fp_reg_num;
logic [4:0] pair_reg_num, pair_high_reg_r, pair_low_reg_r;
logic result_valid_r, align_error_r, align_advised_r, odd_reg_ok_r;
int_decoded_t int_result_r;
fp_decoded_t fp_result_r;
logic [31:0] signed_double_high_word_r, signed_double_low_word_r, unsigned_double_high_word_r;
logic [31:0] unsigned_double_low_word_r, fp_double_upper_word_r, fp_double_lower_word_r;
logic [31:0] fp_quad_word_first_r, fp_quad_word_second_r, fp_quad_word_third_r;
logic [31:0] fp_quad_word_fourth_r;
logic [63:0] signed_extended_value_r, unsigned_extended_value_r;
int seed = 32'h70892eac, fails = 0, check_count = 0;
exp_t q[$];
exp_t e;
always #12.5 clk = ~clk;
lsu_model lsu_u (.*);
data_format_unpacker dut_u (.*);
function automatic fp_decoded_t fp_exp(fp_prec_t p, logic [127:0] v);
    fp_decoded_t d;
    logic [14:0] x, mx;
    logic [15:0] b, mn;
    case (p)
        FP_SINGLE: {d.sign, x, mx, d.frac, b, mn} =
            {v[31], 7'h0, v[30:23], 15'h00ff, v[22:0], 89'h0, SP_BIAS, SP_EMIN};
        FP_DOUBLE: {d.sign, x, mx, d.frac, b, mn} =
            {v[63], 4'h0, v[62:52], 15'h07ff, v[51:0], 60'h0, DP_BIAS, DP_EMIN};
        default: {d.sign, x, mx, d.frac, b, mn} =
            {v[127], v[126:112], 15'h7fff, v[111:0], QP_BIAS, QP_EMIN};
    endcase
    d.implicit_one = x != 0 && x != mx;
    d.exp_unbiased = d.implicit_one ? {1'b0, x} - b : mn;
    if (x == 0) d.cls = d.frac == 0 ? CLS_ZERO : CLS_SUBNORMAL;
    else if (x != mx) d.cls = CLS_NORMAL;
    else if (d.frac == 0) d.cls = CLS_INFINITY;
    else d.cls = d.frac[111] ? CLS_QNAN : CLS_SNAN;
    return d;
endfunction
function automatic logic [127:0] fpv(int p, int k);
    int ew, fw;
    logic [127:0] x, f;
    ew = p == 0 ? 8 : p == 1 ? 11 : 15;
    fw = p == 0 ? 23 : p == 1 ? 52 : 112;
    x = k < 2 ? 128'h0 : (128'h1 << ew) - (k == 2 ? 2 : 1);
    f = (k == 1 || k == 5) ? 128'h1 : k == 4 ? 128'h1 << (fw - 1) : 128'h0;
    return (128'((k ^ p) % 2) << (ew + fw)) | (x << fw) | f;
endfunction
function automatic exp_t calc();
    exp_t c;
    logic [127:0] s;
    int sh;
    sh = 64 - (8 << int_size);
    c.i.signed_value = $signed(int_operand << sh) >>> sh;
    c.i.unsigned_value = int_operand & ~(64'hffffffffffffffff << (8 << int_size));
    c.i.tag = int_operand[1:0];
    c.i.tag_value = 64'($signed(int_operand[31:2]));
    c.f = fp_exp(fp_prec, fp_operand);
    c.w = fp_operand;
    s = fp_prec == FP_DOUBLE ? {64'h0, fp_operand[63:0]} : fp_operand;
    if (little_endian) c.m = {<<8{s}};
    else c.m = s;
    c.g = {mem_addr[1:0] != 0, fp_prec == FP_DOUBLE ? mem_addr[2:0] == 0 :
        fp_prec == FP_QUAD ? mem_addr[3:0] == 0 : 1'b1, !fp_reg_num[0] || fp_reg_num <= 31,
        pair_reg_num & 5'h1e, pair_reg_num | 5'h01};
    return c;
endfunction
task chk(string n, logic [511:0] x, logic [511:0] g);
    check_count++;
    if (g !== x) begin
        fails++;
        $display("unexpected %s: expected %h seen %h", n, x, g);
    end
endtask
task send(int_size_t sz, logic [63:0] io, fp_prec_t p, logic [127:0] fo, logic le, logic mis);
    @(posedge clk);
    {op_valid, int_size, int_operand, fp_prec} <= {1'b1, sz, io, p};
    {fp_operand, little_endian, misalign} <= {fo, le, mis};
    #1 q.push_back(calc());
endtask
task idle();
    @(posedge clk);
    op_valid <= 0;
endtask
task do_reset();
    idle();
    sys_rst <= 1;
    repeat (20) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    #1 chk("reset", 0, {result_valid_r, int_result_r, fp_result_r, mem_image_r, align_error_r});
endtask
task print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
always @(negedge clk) begin
    if (result_valid_r === 1'b1) begin
        if (q.size() == 0) chk("extra result", 0, 1);
        else begin
            e = q.pop_front();
            chk("int", e.i, int_result_r);
            chk("fp", e.f, fp_result_r);
            chk("image", e.m, mem_image_r);
            chk("flags", e.g, {align_error_r, align_advised_r, odd_reg_ok_r,
                pair_high_reg_r, pair_low_reg_r});
            chk("words", {e.i.signed_value, e.i.signed_value, e.i.unsigned_value,
                e.i.unsigned_value, e.w, e.w[63:0]}, {signed_double_high_word_r,
                signed_double_low_word_r, signed_extended_value_r, unsigned_double_high_word_r,
                unsigned_double_low_word_r, unsigned_extended_value_r, fp_quad_word_first_r,
                fp_quad_word_second_r, fp_quad_word_third_r, fp_quad_word_fourth_r,
                fp_double_upper_word_r, fp_double_lower_word_r});
        end
    end
end
initial begin
    repeat (5000) @(posedge clk);
    fails++;
    print_verdict();
end
initial begin
    do_reset();
    for (int p = 0; p < 3; p++)
        for (int k = 0; k < 6; k++) send(INT_WORD, 64'h0, fp_prec_t'(p), fpv(p, k), k[0], 0);
    for (int s = 0; s < 4; s++)
        send(int_size_t'(s), 64'hf0f0000080008081 ^ 64'(s), FP_QUAD, {4{32'h7fff8000}}, s[0], s[1]);
    idle();
    do_reset();
    repeat (150) begin
        r = $random(seed);
        send(int_size_t'(r[1:0]), {$random(seed), $random(seed)}, fp_prec_t'(r[3:2] % 3),
            {$random(seed), $random(seed), $random(seed), $random(seed)}, r[4], r[5]);
        if (r[7:6] == 0) idle();
    end
    repeat (3) idle();
    chk("pending", 0, q.size());
    print_verdict();
end
endmodule
